// ==== design/device_health_status_bank.v ====
// Device health and channel limit status registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`include "health_status_defs.vh"
`default_nettype none

module device_health_status_bank #(
  parameter RES_W  = 20,
  parameter N_CHAN = 8
) (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire [11:0]             s_axi_awaddr,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [11:0]             s_axi_araddr,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  input  wire                    conv_busy,
  input  wire                    state_corrupt,
  input  wire                    trim_check_fault,
  input  wire [7:0]              host_port_status,
  input  wire [N_CHAN-1:0]       chan_sleep,
  input  wire                    power_down,
  input  wire                    result_valid,
  input  wire [2:0]              result_chan,
  input  wire [RES_W-1:0]        result_value,
  input  wire [N_CHAN*RES_W-1:0] high_limits,
  input  wire [N_CHAN*RES_W-1:0] low_limits,
  input  wire                    map_byte_valid,
  input  wire                    map_byte_first,
  input  wire                    map_byte_last,
  input  wire [7:0]              map_byte,
  output wire                    check_fault_inject,
  output wire                    irq
);

  // One byte into the map checksum, most significant bit first
  function [15:0] crc_byte;
    input [15:0] crc_in;
    input [7:0]  data;
    integer      i;
    reg   [15:0] c;
    reg          fb;
    begin
      c = crc_in;
      for (i = 7; i >= 0; i = i - 1) begin
        fb = c[15] ^ data[i];
        c  = {c[14:0], 1'b0} ^ (fb ? `MAP_CRC_POLY : 16'h0000);
      end
      crc_byte = c;
    end
  endfunction

  // W1C flag update where a set wins over a clear
  function [7:0] w1c;
    input [7:0] cur;
    input [7:0] clr;
    input [7:0] set;
    begin
      w1c = (cur & ~clr) | set;
    end
  endfunction

  reg                 aw_held_q;
  reg  [11:0]         aw_addr_q;
  reg                 w_held_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;
  reg                 dev_ok_q;
  reg                 init_done_q;
  reg  [3:0]          health_q;
  reg  [7:0]          high_q;
  reg  [7:0]          low_q;
  reg  [15:0]         checksum_q;
  reg  [7:0]          ctrl_q;
  reg  [`IRQ_BITS-1:0] irq_st_q;
  reg  [`IRQ_BITS-1:0] irq_mask_q;
  reg  [15:0]         crc_q;
  reg                 busy_s1_q;
  reg                 busy_s2_q;
  reg                 busy_s3_q;
  reg                 busy_q;

  wire       wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
  wire [7:0] wr_idx  = aw_addr_q[9:2];
  wire [7:0] rd_idx  = s_axi_araddr[9:2];
  wire       wr_b0   = wr_go && w_strb_q[0];
  wire [7:0] wclr    = w_data_q[7:0];

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready  = !w_held_q;
  assign s_axi_arready = !s_axi_rvalid;

  // Busy pin synchroniser; a change counts once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      busy_s3_q <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      busy_s1_q <= conv_busy;
      busy_s2_q <= busy_s1_q;
      busy_s3_q <= busy_s2_q;
      if (busy_s2_q == busy_s3_q) begin
        busy_q <= busy_s3_q;
      end
    end
  end

  wire busy_fall = busy_q && (busy_s2_q == busy_s3_q) && !busy_s3_q;

  // Limit comparison for the result of the current channel
  wire [RES_W-1:0] hi_lim = high_limits[result_chan*RES_W +: RES_W];
  wire [RES_W-1:0] lo_lim = low_limits[result_chan*RES_W +: RES_W];
  wire [7:0] chan_bit   = 8'h01 << result_chan;
  wire [7:0] high_set   = (result_valid && result_value > hi_lim) ? chan_bit : 8'h00;
  wire [7:0] low_set    = (result_valid && result_value < lo_lim) ? chan_bit : 8'h00;

  wire inject_hit = ctrl_q[`CB_FAULT_INJECT] && result_valid;
  wire [15:0] crc_next = crc_byte(map_byte_first ? `MAP_CRC_INIT : crc_q, map_byte);
  wire map_mismatch    = map_byte_valid && map_byte_last && (crc_next != checksum_q);
  wire trim_set        = trim_check_fault || inject_hit;
  wire map_set         = map_mismatch || inject_hit;
  wire ok_lost         = dev_ok_q && init_done_q && state_corrupt;

  assign check_fault_inject = ctrl_q[`CB_FAULT_INJECT];

  // Write-one-to-clear strobes, lane 0 only
  wire clr_restart = wr_b0 && wr_idx == `IDX_HEALTH && wclr[`HB_RESTART_SEEN];
  wire clr_trim    = wr_b0 && wr_idx == `IDX_HEALTH && wclr[`HB_TRIM_ERR];
  wire clr_map     = wr_b0 && wr_idx == `IDX_HEALTH && wclr[`HB_MAP_ERR];

  // Limit status clear masks
  wire [7:0] high_clr = (wr_b0 && wr_idx == `IDX_HIGH_LIMIT) ? wclr : 8'h00;
  wire [7:0] low_clr  = (wr_b0 && wr_idx == `IDX_LOW_LIMIT) ? wclr : 8'h00;

  wire [7:0] irq_clr  = (wr_b0 && wr_idx == `IDX_IRQ_STATUS) ? wclr : 8'h00;
  wire [7:0] irq_set  = {3'h0, |low_set, |high_set, map_set, trim_set, ok_lost};
  wire [7:0] irq_st_d = w1c({3'h0, irq_st_q}, irq_clr, irq_set);

  // Next values of the latched health flags
  wire restart_d = health_q[2] && !clr_restart;
  wire trim_d    = (health_q[1] && !clr_trim) || trim_set;
  wire map_d     = (health_q[0] && !clr_map) || map_set;

  // Health register read value
  wire [7:0] health_rd;
  assign health_rd[`HB_DEVICE_OK]     = dev_ok_q;
  assign health_rd[`HB_RESTART_SEEN]  = health_q[2];
  assign health_rd[`HB_TRIM_ERR]      = health_q[1];
  assign health_rd[`HB_MAP_ERR]       = health_q[0];
  assign health_rd[`HB_HOST_PORT_ERR] = |host_port_status;
  assign health_rd[`HB_RANGE_VIOL]    = |(high_q | low_q);
  assign health_rd[`HB_POWERED_DOWN]  = power_down;
  assign health_rd[`HB_CHAN_SLEEP]    = |chan_sleep;

  // Status flags and configuration
  always @(posedge aclk) begin
    if (!aresetn) begin
      dev_ok_q    <= 1'b0;
      init_done_q <= 1'b0;
      health_q    <= `RST_HEALTH_LATCH;
      high_q      <= `RST_LIMIT_STATUS;
      low_q       <= `RST_LIMIT_STATUS;
      checksum_q  <= `RST_MAP_CHECKSUM;
      ctrl_q      <= `RST_DEVICE_CTRL;
      irq_st_q    <= `RST_IRQ;
      irq_mask_q  <= `RST_IRQ;
      crc_q       <= `MAP_CRC_INIT;
    end else begin
      if (busy_fall && !init_done_q) begin
        dev_ok_q    <= 1'b1;
        init_done_q <= 1'b1;
      end else if (ok_lost) begin
        dev_ok_q <= 1'b0;
      end
      if (map_byte_valid) begin
        crc_q <= crc_next;
      end
      health_q[2] <= restart_d;
      health_q[1] <= trim_d;
      health_q[0] <= map_d;
      health_q[3] <= 1'b0;
      high_q <= w1c(high_q, high_clr, high_set);
      low_q  <= w1c(low_q, low_clr, low_set);
      irq_st_q <= irq_st_d[`IRQ_BITS-1:0];
      if (wr_go && wr_idx == `IDX_MAP_CHECKSUM) begin
        if (w_strb_q[0]) begin
          checksum_q[7:0] <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          checksum_q[15:8] <= w_data_q[15:8];
        end
      end
      if (wr_b0 && wr_idx == `IDX_DEVICE_CTRL) begin
        ctrl_q <= w_data_q[7:0];
      end
      if (wr_b0 && wr_idx == `IDX_IRQ_MASK) begin
        irq_mask_q <= w_data_q[`IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

  // Address decode for reads and writes
  function known_idx;
    input [7:0] idx;
    begin
      if (idx == `IDX_HEALTH) begin
        known_idx = 1'b1;
      end else if (idx == `IDX_HIGH_LIMIT || idx == `IDX_LOW_LIMIT) begin
        known_idx = 1'b1;
      end else if (idx == `IDX_MAP_CHECKSUM || idx == `IDX_DEVICE_CTRL) begin
        known_idx = 1'b1;
      end else if (idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_MASK) begin
        known_idx = 1'b1;
      end else begin
        known_idx = 1'b0;
      end
    end
  endfunction

  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    if (rd_idx == `IDX_HEALTH) begin
      rd_val[7:0] = health_rd;
    end else if (rd_idx == `IDX_HIGH_LIMIT) begin
      rd_val[7:0] = high_q;
    end else if (rd_idx == `IDX_LOW_LIMIT) begin
      rd_val[7:0] = low_q;
    end else if (rd_idx == `IDX_MAP_CHECKSUM) begin
      rd_val[15:0] = checksum_q;
    end else if (rd_idx == `IDX_DEVICE_CTRL) begin
      rd_val[7:0] = ctrl_q;
    end else if (rd_idx == `IDX_IRQ_STATUS) begin
      rd_val[`IRQ_BITS-1:0] = irq_st_q;
    end else if (rd_idx == `IDX_IRQ_MASK) begin
      rd_val[`IRQ_BITS-1:0] = irq_mask_q;
    end
  end

  // AXI4-Lite write and read channels
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q    <= 1'b0;
      aw_addr_q    <= 12'h000;
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_idx(wr_idx) && aw_addr_q[11:10] == 2'b00 ?
                        `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= known_idx(rd_idx) && s_axi_araddr[11:10] == 2'b00 ?
                        `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== shared/health_status_defs.vh ====
// Offsets, field positions, reset values and constants of the health status bank
`ifndef HEALTH_STATUS_DEFS_VH
`define HEALTH_STATUS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_HEALTH        8'h20
`define IDX_HIGH_LIMIT    8'h21
`define IDX_LOW_LIMIT     8'h22
`define IDX_MAP_CHECKSUM  8'h23
`define IDX_DEVICE_CTRL   8'h25
`define IDX_IRQ_STATUS    8'h30
`define IDX_IRQ_MASK      8'h31

// Health register fields
`define HB_DEVICE_OK      7
`define HB_RESTART_SEEN   6
`define HB_TRIM_ERR       5
`define HB_MAP_ERR        4
`define HB_HOST_PORT_ERR  3
`define HB_RANGE_VIOL     2
`define HB_POWERED_DOWN   1
`define HB_CHAN_SLEEP     0

// Device control field
`define CB_FAULT_INJECT   7

// Interrupt status and mask fields
`define IB_OK_LOST        0
`define IB_TRIM_ERR       1
`define IB_MAP_ERR        2
`define IB_HIGH_LIMIT     3
`define IB_LOW_LIMIT      4
`define IRQ_BITS          5

// Reset values
`define RST_HEALTH_LATCH  4'h4
`define RST_HEALTH        8'h40
`define RST_LIMIT_STATUS  8'h00
`define RST_MAP_CHECKSUM  16'h0000
`define RST_DEVICE_CTRL   8'h00
`define RST_IRQ           5'h00

// Checksum polynomial and start value
`define MAP_CRC_POLY      16'h755b
`define MAP_CRC_INIT      16'hffff

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ==== verif/device_health_status_bank_test.sv ====
// Self-checking bench for the health status register bank
`include "health_status_defs.vh"
`default_nettype none
module device_health_status_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] HL = 12'h080, HI = 12'h084, LO = 12'h088, CK = 12'h08c;
  localparam logic [11:0] CT = 12'h094, IS = 12'h0c0, IM = 12'h0c4;
  logic         aclk = 0, aresetn = 0, irq, check_fault_inject;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic         conv_busy = 0, state_corrupt = 0, trim_check_fault = 0, power_down = 0;
  logic         result_valid = 0, map_byte_valid = 0, map_byte_first = 0, map_byte_last = 0;
  logic [7:0]   host_port_status = 0, chan_sleep = 0, map_byte = 0, hi_e, lo_e, b;
  logic [2:0]   result_chan = 0;
  logic [19:0]  result_value = 0, h, l, v;
  logic [159:0] high_limits = 0, low_limits = 0;
  int           failures = 0, checked = 0;
  always #5 aclk = ~aclk;
  device_health_status_bank u_dut (.*);
  host_model u_host (.*);
  task automatic final_report;
    if (u_host.tmo) failures++;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    u_host.rd(a, rd);
    if (u_host.tmo) final_report();
    chk(rd, e);
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d);
    u_host.wr(a, d);
    if (u_host.tmo) final_report();
  endtask
  task automatic conv(input logic [2:0] c, input logic [19:0] x);
    result_chan <= c;
    result_value <= x;
    result_valid <= 1'b1;
    @(posedge aclk);
    result_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic mapb(input logic [7:0] x);
    map_byte <= x;
    {map_byte_valid, map_byte_first, map_byte_last} <= 3'b111;
    @(posedge aclk);
    map_byte_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  function automatic logic [15:0] crc(input logic [7:0] x);
    logic [15:0] c;
    c = `MAP_CRC_INIT;
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ x[i]) ? `MAP_CRC_POLY : 16'h0);
    return c;
  endfunction
  initial begin
    void'($urandom(32'h768b));
    rst();
    rdc(HL, 32'h40);
    rdc(HI, 32'h0);
    rdc(12'h090, 32'h0);
    chk({30'h0, u_host.last_resp}, 32'h2);
    wrc(HL, 32'h40);
    rdc(HL, 32'h0);
    conv_busy <= 1'b1;
    repeat (6) @(posedge aclk);
    conv_busy <= 1'b0;
    repeat (8) @(posedge aclk);
    wrc(HL, 32'h8f);
    rdc(HL, 32'h80);
    for (int k = 0; k < 12; k++) begin
      host_port_status <= 8'($urandom) & {8{k[0]}};
      chan_sleep <= 8'($urandom) & {8{k[1]}};
      power_down <= k[2];
      @(posedge aclk);
      rdc(HL, {24'h8, |host_port_status, 1'b0, power_down, |chan_sleep});
    end
    {host_port_status, chan_sleep, power_down} <= '0;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        h = 20'($urandom);
        l = 20'($urandom);
        v = p ? 20'($urandom) : h;
        high_limits[c*20 +: 20] <= h;
        low_limits[c*20 +: 20] <= l;
        conv(3'(c), v);
        hi_e[c] = v > h;
        lo_e[c] = v < l;
      end
      rdc(HI, {24'h0, hi_e});
      rdc(LO, {24'h0, lo_e});
      rdc(HL, {24'h8, 1'b0, |(hi_e | lo_e), 2'b00});
      wrc(HI, 32'hff);
      wrc(LO, 32'hff);
      rdc(HI, 32'h0);
      rdc(LO, 32'h0);
    end
    high_limits <= '1;
    low_limits <= '0;
    wrc(CT, 32'h80);
    conv(3'd0, 20'h0);
    rdc(HL, 32'hb0);
    wrc(CT, 32'h0);
    wrc(HL, 32'h30);
    rdc(HL, 32'h80);
    wrc(IS, 32'h1f);
    wrc(IM, 32'h02);
    chk({31'h0, irq}, 32'h0);
    trim_check_fault <= 1'b1;
    @(posedge aclk);
    trim_check_fault <= 1'b0;
    rdc(HL, 32'ha0);
    chk({31'h0, irq}, 32'h1);
    wrc(IM, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wrc(IM, 32'h02);
    wrc(IS, 32'h1f);
    chk({31'h0, irq}, 32'h0);
    state_corrupt <= 1'b1;
    @(posedge aclk);
    state_corrupt <= 1'b0;
    rdc(HL, 32'h20);
    rst();
    rdc(HL, 32'h40);
    b = 8'($urandom);
    wrc(CK, {16'h0, crc(b)});
    rdc(CK, {16'h0, crc(b)});
    mapb(b);
    rdc(HL, 32'h40);
    mapb(~b);
    rdc(HL, 32'h50);
    final_report();
  end
endmodule
bind device_health_status_bank health_bank_checker #(.N_CHAN(N_CHAN)) u_chk (.*);
`default_nettype wire

// ==== verif/health_bank_checker.sv ====
// Assertion checker on the health status bank ports
`default_nettype none
module health_bank_checker #(
  parameter N_CHAN = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [11:0]       s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic [7:0]        host_port_status,
  input wire logic [N_CHAN-1:0] chan_sleep,
  input wire logic              power_down,
  input wire logic              result_valid,
  input wire logic              check_fault_inject,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_go  = s_axi_arvalid && !s_axi_rvalid;
  wire rd_hl  = ar_go && s_axi_araddr == 12'h080;
  wire hp_any = |host_port_status;
  wire sl_any = |chan_sleep;
  wire wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  property p_hp; rd_hl |=> s_axi_rdata[3] == $past(hp_any); endproperty
  a_hp: assert property (p_hp) else $error("bit 3 wrong");
  property p_pd; rd_hl |=> s_axi_rdata[1] == $past(power_down); endproperty
  a_pd: assert property (p_pd) else $error("bit 1 wrong");
  property p_sl; rd_hl |=> s_axi_rdata[0] == $past(sl_any); endproperty
  a_sl: assert property (p_sl) else $error("bit 0 wrong");
  property p_hw; rd_hl |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'b00; endproperty
  a_hw: assert property (p_hw) else $error("health read wrong");
  property p_hi;
    ar_go && s_axi_araddr == 12'h084 |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rresp == 2'b00;
  endproperty
  a_hi: assert property (p_hi) else $error("limit read wrong");
  property p_um;
    ar_go && s_axi_araddr == 12'h090 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_um: assert property (p_um) else $error("unmapped read wrong");
  property p_rl; ar_go ##1 s_axi_rready |-> s_axi_rvalid ##1 !s_axi_rvalid; endproperty
  a_rl: assert property (p_rl) else $error("read answer wrong");
  property p_bl; wr_go ##2 s_axi_bready |-> s_axi_bvalid ##1 !s_axi_bvalid; endproperty
  a_bl: assert property (p_bl) else $error("write answer wrong");
  c_irq: cover property (irq);
  c_inj: cover property (check_fault_inject && result_valid);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ==== verif/host_model.sv ====
// Host model: AXI4-Lite master with bounded waits
`default_nettype none
module host_model (
  input  wire logic        aclk,
  output var  logic [11:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [11:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_resp = 2'b00;
  logic       tmo       = 1'b0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
      if (s_axi_bvalid) break;
    end
    tmo = tmo | (n == 50);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    tmo = tmo | (n == 50);
  endtask
endmodule
`default_nettype wire
